/* src/blit_regs.sv */
// Indexed register bank for blit size and foreground color high byte
`timescale 1ns/1ns
`default_nettype none
`include "blit_regs_defines.svh"

module blit_regs
	import blit_regs_pkg::*;
(
	input  wire logic       CLK_I,
	input  wire logic       SRST_I,
	input  wire reg_req_t   REQ_I,
	input  wire logic [7:0] FG_LOW_I,
	output var  logic [7:0] RDATA_O,
	output var  logic       RHIT_O,
	output var  blit_cfg_t  CFG_O
);

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] fg_high_q,   fg_high_d;
	logic [7:0] width_lo_q,  width_lo_d;
	logic [2:0] width_hi_q,  width_hi_d;
	logic [7:0] height_lo_q, height_lo_d;
	logic [1:0] height_hi_q, height_hi_d;
	logic [7:0] rdata_q,     rdata_d;
	logic       rhit_q,      rhit_d;

	always_comb begin
		fg_high_d   = fg_high_q;
		width_lo_d  = width_lo_q;
		width_hi_d  = width_hi_q;
		height_lo_d = height_lo_q;
		height_hi_d = height_hi_q;
		if (REQ_I.wr) begin
			case (REQ_I.index)
				`IDX_FG_HIGH: begin
					fg_high_d = REQ_I.wdata;
				end
				`IDX_WIDTH_LOW: begin
					width_lo_d = REQ_I.wdata;
				end
				`IDX_WIDTH_HIGH: begin
					width_hi_d = REQ_I.wdata[`WIDTH_HIGH_BITS-1:0];
				end
				`IDX_HEIGHT_LOW: begin
					height_lo_d = REQ_I.wdata;
				end
				`IDX_HEIGHT_HIGH: begin
					height_hi_d = REQ_I.wdata[`HEIGHT_HIGH_BITS-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Write side registers
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			fg_high_q   <= `RST_FG_HIGH;
			width_lo_q  <= `RST_WIDTH_LOW;
			width_hi_q  <= `RST_WIDTH_HIGH;
			height_lo_q <= `RST_HEIGHT_LOW;
			height_hi_q <= `RST_HEIGHT_HIGH;
		end else begin
			fg_high_q   <= fg_high_d;
			width_lo_q  <= width_lo_d;
			width_hi_q  <= width_hi_d;
			height_lo_q <= height_lo_d;
			height_hi_q <= height_hi_d;
		end
	end

	// ****************************************
	// Write side assertions
	// ****************************************
	// high byte taken
	a_fg_high_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.wr && REQ_I.index == `IDX_FG_HIGH) |=> CFG_O.fg_color[15:8] == $past(REQ_I.wdata))
		else $error("foreground high byte not taken");
	a_fg_high_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!(REQ_I.wr && REQ_I.index == `IDX_FG_HIGH) |=> $stable(CFG_O.fg_color[15:8]))
		else $error("foreground high byte changed without a write");
	a_fg_reset: assert property (@(posedge CLK_I) disable iff (SRST_I)
		$past(SRST_I) |-> CFG_O.fg_color[15:8] == `RST_FG_HIGH)
		else $error("foreground high byte reset value wrong");
	a_fg_low_pass: assert property (@(posedge CLK_I) disable iff (SRST_I)
		CFG_O.fg_color[7:0] == FG_LOW_I)
		else $error("foreground low byte not from external register");

	a_width_high_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.wr && REQ_I.index == `IDX_WIDTH_HIGH) |=> CFG_O.width_bytes[10:8] == $past(REQ_I.wdata[2:0]))
		else $error("width high bits wrong");
	a_width_low_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.wr && REQ_I.index == `IDX_WIDTH_LOW) |=> CFG_O.width_bytes[7:0] == $past(REQ_I.wdata))
		else $error("width low byte wrong");
	a_width_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!(REQ_I.wr && (REQ_I.index == `IDX_WIDTH_LOW || REQ_I.index == `IDX_WIDTH_HIGH))
		|=> $stable(CFG_O.width_bytes))
		else $error("width changed without a write");
	a_width_reset: assert property (@(posedge CLK_I) disable iff (SRST_I)
		$past(SRST_I) |-> CFG_O.width_bytes == {`RST_WIDTH_HIGH, `RST_WIDTH_LOW})
		else $error("width reset value wrong");

	a_height_high_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.wr && REQ_I.index == `IDX_HEIGHT_HIGH) |=> CFG_O.height_lines[9:8] == $past(REQ_I.wdata[1:0]))
		else $error("height high bits wrong");
	a_height_low_write: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.wr && REQ_I.index == `IDX_HEIGHT_LOW) |=> CFG_O.height_lines[7:0] == $past(REQ_I.wdata))
		else $error("height low byte wrong");
	a_height_hold: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!(REQ_I.wr && (REQ_I.index == `IDX_HEIGHT_LOW || REQ_I.index == `IDX_HEIGHT_HIGH))
		|=> $stable(CFG_O.height_lines))
		else $error("height changed without a write");
	a_height_reset: assert property (@(posedge CLK_I) disable iff (SRST_I)
		$past(SRST_I) |-> CFG_O.height_lines == {`RST_HEIGHT_HIGH, `RST_HEIGHT_LOW})
		else $error("height reset value wrong");

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rdata_d = rdata_q;
		rhit_d  = 1'h0;
		if (REQ_I.rd) begin
			rhit_d = 1'h1;
			case (REQ_I.index)
				`IDX_FG_HIGH:     rdata_d = fg_high_q;
				`IDX_WIDTH_LOW:   rdata_d = width_lo_q;
				`IDX_WIDTH_HIGH:  rdata_d = {5'h00, width_hi_q};
				`IDX_HEIGHT_LOW:  rdata_d = height_lo_q;
				`IDX_HEIGHT_HIGH: rdata_d = {6'h00, height_hi_q};
				default: begin
					rdata_d = 8'h00;
					rhit_d  = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rdata_q <= 8'h00;
			rhit_q  <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			rhit_q  <= rhit_d;
		end
	end

	// ****************************************
	// Read side assertions
	// ****************************************
	// high byte readback
	a_fg_high_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_FG_HIGH) |=> RHIT_O && RDATA_O == $past(CFG_O.fg_color[15:8]))
		else $error("foreground high byte readback wrong");
	a_width_low_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_WIDTH_LOW) |=> RHIT_O && RDATA_O == $past(CFG_O.width_bytes[7:0]))
		else $error("width low byte readback wrong");
	a_width_high_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_WIDTH_HIGH) |=> RDATA_O[2:0] == $past(CFG_O.width_bytes[10:8]))
		else $error("width high bits readback wrong");
	a_width_rsvd_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_WIDTH_HIGH) |=> RHIT_O && RDATA_O[7:3] == 5'h00)
		else $error("width high reserved bits not zero");
	a_height_low_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_HEIGHT_LOW) |=> RHIT_O && RDATA_O == $past(CFG_O.height_lines[7:0]))
		else $error("height low byte readback wrong");
	a_height_high_read: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_HEIGHT_HIGH) |=> RDATA_O[1:0] == $past(CFG_O.height_lines[9:8]))
		else $error("height high bits readback wrong");
	a_height_rsvd_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(REQ_I.rd && REQ_I.index == `IDX_HEIGHT_HIGH) |=> RHIT_O && RDATA_O[7:2] == 6'h00)
		else $error("height high reserved bits not zero");

	// ****************************************
	// Assembled fields
	// ****************************************
	// foreground color
	assign CFG_O.fg_color     = {fg_high_q, FG_LOW_I};
	assign CFG_O.width_bytes  = {width_hi_q, width_lo_q};
	assign CFG_O.height_lines = {height_hi_q, height_lo_q};
	// Registered read answer
	assign RDATA_O            = rdata_q;
	assign RHIT_O             = rhit_q;

endmodule
`default_nettype wire

/* src/blit_regs_defines.svh */
// Offsets, field widths and reset values of the blit size and foreground color registers
`ifndef BLIT_REGS_DEFINES_SVH
`define BLIT_REGS_DEFINES_SVH

`define IDX_FG_HIGH      8'h11
`define IDX_WIDTH_LOW    8'h20
`define IDX_WIDTH_HIGH   8'h21
`define IDX_HEIGHT_LOW   8'h22
`define IDX_HEIGHT_HIGH  8'h23

`define RST_FG_HIGH      8'hFF
`define RST_WIDTH_LOW    8'hFF
`define RST_WIDTH_HIGH   3'h7
`define RST_HEIGHT_LOW   8'h0F
`define RST_HEIGHT_HIGH  2'h3

`define WIDTH_HIGH_BITS  3
`define HEIGHT_HIGH_BITS 2

`endif

/* src/blit_regs_pkg.sv */
// Types shared by the blit size and foreground color register bank
`default_nettype none
package blit_regs_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] fg_color;
		logic [10:0] width_bytes;
		logic [9:0]  height_lines;
	} blit_cfg_t;

endpackage
`default_nettype wire

/* bench/blit_regs_tb.sv */
// Self-checking testbench for the blit size and foreground color register bank
`timescale 1ns/1ns
`default_nettype none
module blit_regs_tb import blit_regs_pkg::*; ;
	logic       clk, srst, rhit;
	reg_req_t   req;
	logic [7:0] fg_lo, rdata;
	blit_cfg_t  cfg;
	int         n_fail, cmp_count;
	blit_regs dut_u (.CLK_I(clk), .SRST_I(srst), .REQ_I(req), .FG_LOW_I(fg_lo),
		.RDATA_O(rdata), .RHIT_O(rhit), .CFG_O(cfg));
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One access, answer settled at the following falling edge
	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(negedge clk) req = '{w, !w, i, d};
		@(negedge clk) req = '0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic h);
		acc(1'h0, i, 8'h00);
		cmp({8'h00, rdata}, {8'h00, e});
		cmp({15'h0000, rhit}, {15'h0000, h});
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_reset;
		cmp(cfg.width_bytes, 16'h07FF);
		cmp(cfg.height_lines, 16'h030F);
		cmp(cfg.fg_color, 16'hFF5A);
		rd(8'h11, 8'hFF, 1'h1);
		rd(8'h20, 8'hFF, 1'h1);
		rd(8'h21, 8'h07, 1'h1);
		rd(8'h22, 8'h0F, 1'h1);
		rd(8'h23, 8'h03, 1'h1);
	endtask
	task automatic t_width;
		acc(1'h1, 8'h20, 8'hAA);
		acc(1'h1, 8'h21, 8'hFD);
		cmp(cfg.width_bytes, 16'h05AA);
		rd(8'h21, 8'h05, 1'h1);
		@(negedge clk);
		cmp({15'h0000, rhit}, 16'h0000);
		cmp({8'h00, rdata}, 16'h0005);
		rd(8'h20, 8'hAA, 1'h1);
	endtask
	task automatic t_height;
		acc(1'h1, 8'h22, 8'h3C);
		acc(1'h1, 8'h23, 8'hFE);
		cmp(cfg.height_lines, 16'h023C);
		rd(8'h23, 8'h02, 1'h1);
		rd(8'h22, 8'h3C, 1'h1);
	endtask
	task automatic t_fg;
		acc(1'h1, 8'h11, 8'hC3);
		fg_lo = 8'h96;
		@(negedge clk);
		cmp(cfg.fg_color, 16'hC396);
		fg_lo = 8'h69;
		@(negedge clk);
		cmp(cfg.fg_color, 16'hC369);
		rd(8'h11, 8'hC3, 1'h1);
	endtask
	task automatic t_unmapped;
		acc(1'h1, 8'h24, 8'h00);
		rd(8'h24, 8'h00, 1'h0);
		cmp(cfg.width_bytes, 16'h05AA);
		cmp(cfg.height_lines, 16'h023C);
	endtask
	// Read and write of one register in the same cycle
	task automatic t_rdwr;
		@(negedge clk) req = '{1'h1, 1'h1, 8'h20, 8'h55};
		@(negedge clk) req = '0;
		cmp({8'h00, rdata}, 16'h00AA);
		cmp({15'h0000, rhit}, 16'h0001);
		cmp(cfg.width_bytes, 16'h0555);
	endtask
	// Reset in mid-run restores the fields
	task automatic t_midrst;
		@(negedge clk) srst = 1'h1;
		@(negedge clk) srst = 1'h0;
		cmp(cfg.width_bytes, 16'h07FF);
		cmp(cfg.height_lines, 16'h030F);
		cmp(cfg.fg_color, 16'hFF69);
		acc(1'h1, 8'h23, 8'h01);
		cmp(cfg.height_lines, 16'h010F);
	endtask
	initial begin
		n_fail = 0;
		cmp_count = 0;
		srst = 1'h1;
		req = '0;
		fg_lo = 8'h5A;
		repeat (4) @(negedge clk);
		srst = 1'h0;
		t_reset();
		t_width();
		t_height();
		t_fg();
		t_unmapped();
		t_rdwr();
		t_midrst();
		close_out();
	end
endmodule
`default_nettype wire
